// File: inc/dop_pkg.sv
// shared constants and types for the digital output port block
package dop_pkg;

    localparam int NUM_LINES = 16;
    localparam int IDX_W     = 4;

    // register byte offsets
    localparam logic [11:0] OFF_KEEP    = 12'h000;
    localparam logic [11:0] OFF_SETTING = 12'h004;
    localparam logic [11:0] OFF_RANGE   = 12'h008;
    localparam logic [11:0] OFF_VALUE   = 12'h00C;
    localparam logic [11:0] OFF_TOGGLE  = 12'h010;
    localparam logic [11:0] OFF_BANK    = 12'h014;
    localparam logic [11:0] OFF_LEVELS  = 12'h018;

    // per-line setting codes, two bits per line
    localparam logic [1:0] SET_KEEP = 2'h0;
    localparam logic [1:0] SET_LOW  = 2'h1;
    localparam logic [1:0] SET_HIGH = 2'h2;

    // range register field positions
    localparam int RNG_FIRST_LSB = 0;
    localparam int RNG_LAST_LSB  = 4;
    localparam int RNG_REV_BIT   = 8;

    // reset values
    localparam logic [15:0] LEVELS_RST = 16'h0000;
    localparam logic [31:0] REG_RST    = 32'h0000_0000;

    typedef enum logic [2:0] {
        CMD_NONE   = 3'h0,
        CMD_SET    = 3'h1,
        CMD_BITS   = 3'h2,
        CMD_TOGGLE = 3'h3,
        CMD_BANK   = 3'h4
    } dop_cmd_t;

    typedef struct packed {
        dop_cmd_t    cmd;
        logic [31:0] setting;
        logic [3:0]  first;
        logic [3:0]  last;
        logic        reverse;
        logic [15:0] value;
        logic [15:0] mask;
        logic        bank_level;
    } dop_req_t;

endpackage : dop_pkg

// File: hdl/dop_apply.sv
// combinational next-level computation for one output command
`timescale 1ns/1ps
module dop_apply (
    input  wire dop_pkg::dop_req_t req,
    input  wire logic [15:0]       levels,
    output logic [15:0]            levels_next
);

    // spread the value over the range; lines outside the range keep cur
    function automatic logic [15:0] bits_spread(input logic [15:0] cur,
                                                input logic [3:0]  first,
                                                input logic [3:0]  last,
                                                input logic        rev,
                                                input logic [15:0] val);
        logic [15:0] res;
        logic [3:0]  lo;
        logic [3:0]  hi;
        logic [4:0]  pos;
        res = cur;
        lo  = (first <= last) ? first : last;
        hi  = (first <= last) ? last : first;
        for (int i = 0; i < dop_pkg::NUM_LINES; i++) begin
            if (4'(i) >= lo && 4'(i) <= hi) begin
                // field bit index counted from the first port
                pos = (first <= last) ? 5'(4'(i) - first) : 5'(first - 4'(i));
                if (rev) begin
                    pos = 5'(hi - lo) - pos;
                end
                res[i] = val[pos[3:0]];
            end
        end
        return res;
    endfunction : bits_spread

    always_comb begin
        levels_next = levels;
        unique case (req.cmd)
            dop_pkg::CMD_NONE: begin
                levels_next = levels;
            end
            dop_pkg::CMD_SET: begin
                for (int i = 0; i < dop_pkg::NUM_LINES; i++) begin
                    unique case (req.setting[2*i +: 2])
                        dop_pkg::SET_LOW:  levels_next[i] = 1'b0;
                        dop_pkg::SET_HIGH: levels_next[i] = 1'b1;
                        default:           levels_next[i] = levels[i];
                    endcase
                end
            end
            dop_pkg::CMD_BITS: begin
                levels_next = bits_spread(levels, req.first, req.last,
                                          req.reverse, req.value);
            end
            dop_pkg::CMD_TOGGLE: begin
                levels_next = levels ^ req.mask;
            end
            dop_pkg::CMD_BANK: begin
                levels_next = {16{req.bank_level}};
            end
            default: begin
                levels_next = levels;
            end
        endcase
    end

endmodule : dop_apply

// File: hdl/dop_top.sv
// sixteen-line digital output bank with APB command registers
`timescale 1ns/1ps
// How it works
// - sixteen output lines, indexed 0 to 15, each targetable by a command.
// - per-line setting is keep, low or high; unused code acts as keep.
// - keep lines hold their previous level.
// - low lines are driven to zero on apply.
// - high lines are driven to one on apply.
// - present levels of all lines are readable as a status word.
// - first and last index bound an inclusive field of bit positions.
// - value is binary; each range line follows its bit.
// - forward order puts value LSB on the first port.
// - reverse order puts value MSB on the first port.
// - toggle inverts selected lines and leaves others alone.
// - whole-bank command drives all sixteen lines to one level.
module dop_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [15:0]      dout
);

    logic [15:0]       levels_reg;
    logic [15:0]       levels_next;
    logic [31:0]       setting_reg;
    logic [8:0]        range_reg;
    logic [31:0]       prdata_reg;
    logic              pslverr_reg;
    dop_pkg::dop_req_t req;
    logic              wr_acc;
    logic              rd_acc;
    logic              mapped;

    function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction : strb_merge

    assign pready  = 1'b1;
    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && !penable && !pwrite;
    assign pslverr = pslverr_reg;
    assign prdata  = prdata_reg;
    assign dout    = levels_reg;

    always_comb begin
        unique case (paddr)
            dop_pkg::OFF_KEEP, dop_pkg::OFF_SETTING, dop_pkg::OFF_RANGE,
            dop_pkg::OFF_VALUE, dop_pkg::OFF_TOGGLE, dop_pkg::OFF_BANK,
            dop_pkg::OFF_LEVELS: mapped = 1'b1;
            default:             mapped = 1'b0;
        endcase
    end

    // a write to the setting, value, toggle or bank register is the command itself
    always_comb begin
        req            = '0;
        req.cmd        = dop_pkg::CMD_NONE;
        req.setting    = setting_reg;
        req.first      = range_reg[dop_pkg::RNG_FIRST_LSB +: 4];
        req.last       = range_reg[dop_pkg::RNG_LAST_LSB +: 4];
        req.reverse    = range_reg[dop_pkg::RNG_REV_BIT];
        req.value      = pwdata[15:0];
        req.mask       = pwdata[15:0];
        req.bank_level = pwdata[0];
        if (wr_acc) begin
            unique case (paddr)
                dop_pkg::OFF_SETTING: begin
                    req.cmd     = dop_pkg::CMD_SET;
                    req.setting = strb_merge(setting_reg, pwdata, pstrb);
                end
                dop_pkg::OFF_VALUE:  req.cmd = dop_pkg::CMD_BITS;
                dop_pkg::OFF_TOGGLE: req.cmd = dop_pkg::CMD_TOGGLE;
                dop_pkg::OFF_BANK:   req.cmd = dop_pkg::CMD_BANK;
                default:             req.cmd = dop_pkg::CMD_NONE;
            endcase
        end
    end

    dop_apply u_apply (
        .req         (req),
        .levels      (levels_reg),
        .levels_next (levels_next)
    );

    // one register for all lines so every command lands in one edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            levels_reg <= dop_pkg::LEVELS_RST;
        end else begin
            levels_reg <= levels_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setting_reg <= dop_pkg::REG_RST;
        end else if (wr_acc && paddr == dop_pkg::OFF_SETTING) begin
            setting_reg <= req.setting;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_reg <= dop_pkg::REG_RST[8:0];
        end else if (wr_acc && paddr == dop_pkg::OFF_RANGE) begin
            range_reg <= pwdata[8:0];
        end
    end

    // read data captured in setup so it is stable through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= dop_pkg::REG_RST;
        end else if (rd_acc) begin
            unique case (paddr)
                dop_pkg::OFF_SETTING: prdata_reg <= setting_reg;
                dop_pkg::OFF_RANGE:   prdata_reg <= {23'h000000, range_reg};
                dop_pkg::OFF_LEVELS:  prdata_reg <= {16'h0000, levels_reg};
                default:              prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_reg <= !mapped || (pwrite && paddr == dop_pkg::OFF_LEVELS);
        end else if (!psel) begin
            pslverr_reg <= 1'b0;
        end
    end

    logic wr_bank_q;
    logic bank_lvl_q;
    logic wr_tog_q;
    logic [15:0] tog_mask_q;
    logic [15:0] tog_prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_bank_q  <= 1'b0;
            bank_lvl_q <= 1'b0;
            wr_tog_q   <= 1'b0;
            tog_mask_q <= 16'h0000;
            tog_prev_q <= 16'h0000;
        end else begin
            wr_bank_q  <= wr_acc && paddr == dop_pkg::OFF_BANK;
            bank_lvl_q <= pwdata[0];
            wr_tog_q   <= wr_acc && paddr == dop_pkg::OFF_TOGGLE;
            tog_mask_q <= pwdata[15:0];
            tog_prev_q <= levels_reg;
        end
    end

    sequence bank_write_s;
        psel && penable && pwrite && paddr == dop_pkg::OFF_BANK;
    endsequence

    sequence set_write_s;
        psel && penable && pwrite && paddr == dop_pkg::OFF_SETTING && pstrb == 4'hF;
    endsequence

    sequence value_write_s;
        psel && penable && pwrite && paddr == dop_pkg::OFF_VALUE;
    endsequence

    sequence range_write_s;
        psel && penable && pwrite && paddr == dop_pkg::OFF_RANGE;
    endsequence

    // one clock late copy of a full setting write, so each line is judged alone
    logic        wr_set_q;
    logic [31:0] set_word_q;
    logic [15:0] set_prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_set_q   <= 1'b0;
            set_word_q <= dop_pkg::REG_RST;
            set_prev_q <= dop_pkg::LEVELS_RST;
        end else begin
            wr_set_q   <= wr_acc && paddr == dop_pkg::OFF_SETTING && pstrb == 4'hF;
            set_word_q <= pwdata;
            set_prev_q <= levels_reg;
        end
    end

    bank_all_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_bank_q |-> levels_reg == {16{bank_lvl_q}})
        else $error("bank write did not set all lines");

    toggle_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_tog_q |-> levels_reg == (tog_prev_q ^ tog_mask_q))
        else $error("toggle result wrong");

    set_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        set_write_s ##0 (pwdata[1:0] == dop_pkg::SET_LOW) |=> !levels_reg[0])
        else $error("line 0 not low after low setting");

    set_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        set_write_s ##0 (pwdata[1:0] == dop_pkg::SET_HIGH) |=> levels_reg[0])
        else $error("line 0 not high after high setting");

    set_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        set_write_s ##0 (pwdata[1:0] == dop_pkg::SET_KEEP) |=> $stable(levels_reg[0]))
        else $error("kept line changed");

    idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && penable && pwrite) |=> $stable(levels_reg))
        else $error("lines changed without a command");

    bits_fwd_a: assert property (@(posedge pclk) disable iff (!presetn)
        value_write_s ##0 (range_reg == 9'h030)
        |=> levels_reg[3:0] == $past(pwdata[3:0]))
        else $error("forward bit order wrong");

    bits_rev_a: assert property (@(posedge pclk) disable iff (!presetn)
        value_write_s ##0 (range_reg == 9'h130)
        |=> levels_reg[0] == $past(pwdata[3]) && levels_reg[3] == $past(pwdata[0]))
        else $error("reverse bit order wrong");

    bits_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        value_write_s ##0 (range_reg == 9'h030)
        |=> levels_reg[15:4] == $past(levels_reg[15:4]))
        else $error("line outside range changed");

    read_lvl_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == dop_pkg::OFF_LEVELS |=> prdata[15:0] == $past(levels_reg))
        else $error("level readback wrong");

    // partial strobes are left out here; they re-apply stale fields by design
    for (genvar g = 0; g < dop_pkg::NUM_LINES; g++) begin : g_line
        line_code_a: assert property (@(posedge pclk) disable iff (!presetn)
            wr_set_q |-> levels_reg[g] ==
                ((set_word_q[2*g +: 2] == dop_pkg::SET_HIGH) ? 1'b1 :
                 (set_word_q[2*g +: 2] == dop_pkg::SET_LOW)  ? 1'b0 : set_prev_q[g]))
            else $error("line code not applied");
    end

    bits_fwd8_a: assert property (@(posedge pclk) disable iff (!presetn)
        value_write_s ##0 (range_reg == 9'h070)
        |=> levels_reg[7:0] == $past(pwdata[7:0]))
        else $error("eight wide forward order wrong");

    bits_rev8_a: assert property (@(posedge pclk) disable iff (!presetn)
        value_write_s ##0 (range_reg == 9'h170)
        |=> levels_reg[0] == $past(pwdata[7]) && levels_reg[7] == $past(pwdata[0])
            && levels_reg[5] == $past(pwdata[2]))
        else $error("eight wide reverse order wrong");

    one_wide_a: assert property (@(posedge pclk) disable iff (!presetn)
        value_write_s ##0 (range_reg[3:0] == range_reg[7:4])
        |=> levels_reg[$past(range_reg[3:0])] == $past(pwdata[0]))
        else $error("one wide field wrong");

    one_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        value_write_s ##0 (range_reg[3:0] == range_reg[7:4])
        |=> ((levels_reg ^ $past(levels_reg)) & ~(16'h0001 << $past(range_reg[3:0]))) == 16'h0000)
        else $error("line beside one wide field changed");

    range_store_a: assert property (@(posedge pclk) disable iff (!presetn)
        range_write_s |=> range_reg == $past(pwdata[8:0]))
        else $error("range not stored");

    // a range write only arms the next value write, it must not move lines
    range_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        range_write_s |=> $stable(levels_reg))
        else $error("range write moved lines");

    keep_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == dop_pkg::OFF_KEEP |=> $stable(levels_reg))
        else $error("spare offset write moved lines");

    // no disable here: this one must hold while reset is low
    reset_low_a: assert property (@(posedge pclk)
        !presetn |-> dout == dop_pkg::LEVELS_RST)
        else $error("lines not low in reset");

    status_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == dop_pkg::OFF_LEVELS |-> pslverr ##1 $stable(levels_reg))
        else $error("status word write not refused");

    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !mapped |-> pslverr)
        else $error("unmapped access not flagged");

    err_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        !psel |=> !pslverr)
        else $error("error flag left up when idle");

endmodule : dop_top

// File: tb/tb_top.sv
// self-checking bench for the digital output bank, driven over APB
`timescale 1ns/1ps
module tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] dout;
    logic [31:0] rdat;
    logic        rerr;
    logic [15:0] exp_lv;
    int          fail_count;
    int          n_compared;

    dop_top i_dop_top (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .dout    (dout)
    );

    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // setup, then access until pready; read data and error taken at that edge only
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            $display("mismatch at %0t: no pready", $time);
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // write, then look at the lines once the access edge has landed
    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [15:0] e);
        apb(1'b1, a, d);
        @(negedge pclk);
        check({16'h0000, dout}, {16'h0000, e});
    endtask : wr_chk

    initial begin
        fail_count = 0;
        n_compared = 0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h0000_0000;
        pstrb      = 4'hF;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        check({16'h0000, dout}, 32'h0000_0000);
        $display("reset test done");

        wr_chk(dop_pkg::OFF_BANK, 32'h0000_0001, 16'hFFFF);
        wr_chk(dop_pkg::OFF_BANK, 32'h0000_0000, 16'h0000);
        wr_chk(dop_pkg::OFF_TOGGLE, 32'h0000_00FF, 16'h00FF);
        wr_chk(dop_pkg::OFF_TOGGLE, 32'h0000_0F0F, 16'h0FF0);
        $display("bank and toggle test done");

        // lines 0-3 high, 4-7 low, 8-11 keep, 12-15 unused code
        wr_chk(dop_pkg::OFF_SETTING, 32'hFF00_55AA, 16'h0F0F);
        apb(1'b0, dop_pkg::OFF_LEVELS, 32'h0);
        check(rdat, 32'h0000_0F0F);
        check({31'h0, rerr}, 32'h0);
        wr_chk(dop_pkg::OFF_SETTING, 32'h0000_0001, 16'h0F0E);
        wr_chk(dop_pkg::OFF_SETTING, 32'h0000_0000, 16'h0F0E);
        $display("setting test done");

        wr_chk(dop_pkg::OFF_BANK, 32'h0000_0000, 16'h0000);
        apb(1'b1, dop_pkg::OFF_RANGE, 32'h0000_0070);
        wr_chk(dop_pkg::OFF_VALUE, 32'h0000_0064, 16'h0064);
        apb(1'b1, dop_pkg::OFF_RANGE, 32'h0000_0170);
        wr_chk(dop_pkg::OFF_VALUE, 32'h0000_0064, 16'h0026);
        apb(1'b1, dop_pkg::OFF_RANGE, 32'h0000_0030);
        wr_chk(dop_pkg::OFF_VALUE, 32'h0000_0009, 16'h0029);
        apb(1'b1, dop_pkg::OFF_RANGE, 32'h0000_0130);
        wr_chk(dop_pkg::OFF_VALUE, 32'h0000_0001, 16'h0028);
        wr_chk(dop_pkg::OFF_BANK, 32'h0000_0001, 16'hFFFF);
        apb(1'b1, dop_pkg::OFF_RANGE, 32'h0000_00B4);
        wr_chk(dop_pkg::OFF_VALUE, 32'h0000_01A5, 16'hFA5F);
        apb(1'b1, dop_pkg::OFF_RANGE, 32'h0000_01B4);
        wr_chk(dop_pkg::OFF_VALUE, 32'h0000_0003, 16'hFC0F);
        $display("bit field test done");

        // every line alone as a one-wide field, others hold
        wr_chk(dop_pkg::OFF_BANK, 32'h0000_0000, 16'h0000);
        exp_lv = 16'h0000;
        for (int i = 0; i < dop_pkg::NUM_LINES; i++) begin
            exp_lv[i] = 1'b1;
            apb(1'b1, dop_pkg::OFF_RANGE, {24'h0, i[3:0], i[3:0]});
            wr_chk(dop_pkg::OFF_VALUE, 32'h0000_0001, exp_lv);
        end
        $display("single line test done");

        wr_chk(dop_pkg::OFF_KEEP, 32'hFFFF_0000, 16'hFFFF);
        wr_chk(dop_pkg::OFF_LEVELS, 32'h0000_0000, 16'hFFFF);
        check({31'h0, rerr}, 32'h1);
        apb(1'b0, 12'h01C, 32'h0);
        check(rdat, 32'h0);
        check({31'h0, rerr}, 32'h1);
        apb(1'b0, dop_pkg::OFF_RANGE, 32'h0);
        check(rdat, 32'h0000_00FF);
        apb(1'b0, dop_pkg::OFF_LEVELS, 32'h0);
        check(rdat, 32'h0000_FFFF);
        $display("access error test done");

        // reset in mid-run: lines and range fall back, reads see it
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check({16'h0000, dout}, 32'h0000_0000);
        apb(1'b0, dop_pkg::OFF_RANGE, 32'h0);
        check(rdat, 32'h0000_0000);
        apb(1'b0, dop_pkg::OFF_LEVELS, 32'h0);
        check(rdat, 32'h0000_0000);
        $display("mid-run reset test done");
        close_out();
    end

    // whole run is well under 1000 cycles; this only cuts a hang short
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        close_out();
    end
endmodule : tb_top
